/* File: hdl/wdt_core.sv */
// Crystal watchdog timer with its control register on the SFR port.
// Assumes the core drives one SFR byte or bit write per cycle, and the
// crystal level arrives synchronous to clk (125 MHz).
// Operation
// R1 - Disabled watchdog never resets or interrupts; the code still drives wd_irq from a set flag with the interrupt option.
// R2 - Missed refresh causes reset or interrupt.
// R3 - 16-bit counter advances on crystal edges.
// R4 - Prescale lives in control bits 7:4.
// R5 - Timeout is 2^prescale times 512 periods.
// R6 - Every write needs the double-write unlock.
// R7 - Control register resets to hex 10.
// R8 - Control at C0, bit addressable.
// R9 - Interrupt option replaces reset, unmaskable.
// R10 - Software avoids prescale codes above 1000.
// R11 - Accepted refresh write restarts the count.
`timescale 1ns/1ns
`include "wdt_consts.svh"
module wdt_core
  import wdt_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic xtal_level,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  input wire logic sfr_bit_wr,
  input wire logic [7:0] sfr_bit_addr,
  input wire logic sfr_bit_val,
  output logic wd_reset_req,
  output logic wd_irq
);
  logic tick;
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic unlock_q;
  logic unlock_d;
  wdt_cnt_t cnt_q;
  wdt_cnt_t cnt_d;
  logic rst_q;
  logic rst_d;
  logic irq_q;
  logic irq_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic byte_hit;
  logic bit_hit;
  logic hit;
  logic accept;
  logic [7:0] new_val;
  logic refresh;
  logic enabled;
  wdt_pre_t pre;
  wdt_cnt_t terminal;
  logic timeout;

  // ---------------------------------------------------------------
  // Crystal timebase
  // ---------------------------------------------------------------
  wdt_xtal_edge u_edge (
    .clk(clk),
    .arst_n(arst_n),
    .xtal_level(xtal_level),
    .tick(tick)
  );

  // ---------------------------------------------------------------
  // Register access decode
  // ---------------------------------------------------------------
  // Byte writes hit address C0 and bit writes hit bit addresses C0 to C7.
  always_comb begin
    byte_hit = sfr_wr && (sfr_addr == `WDT_CTRL_ADDR); // R8
    bit_hit = sfr_bit_wr && (sfr_bit_addr[7:3] == `WDT_CTRL_BIT_BASE); // R8
    hit = byte_hit | bit_hit;
    new_val = ctrl_q;
    if (byte_hit) begin
      new_val = sfr_wdata;
    end else if (bit_hit) begin
      new_val[sfr_bit_addr[2:0]] = sfr_bit_val; // R8
    end
    accept = hit && unlock_q; // R6
    refresh = accept && new_val[`WDT_BIT_REFRESH];
    enabled = ctrl_q[`WDT_BIT_REFRESH];
    pre = ctrl_q[`WDT_PRE_HI:`WDT_PRE_LO]; // R4
  end

  // ---------------------------------------------------------------
  // Timeout detection
  // ---------------------------------------------------------------
  // The terminal count is a right-shifted all-ones word, so prescale 7 uses
  // the full 16-bit range and prescale 0 ends after 512 crystal periods.
  // Codes at and above 1000 fire at once, so a stray reserved code fails safe.
  always_comb begin
    terminal = `WDT_CNT_FULL >> (`WDT_PRE_MAX_TIMED - {1'b0, pre[2:0]}); // R5
    timeout = 1'b0;
    if (enabled) begin // R1
      if (pre >= `WDT_PRE_IMMEDIATE) begin
        timeout = 1'b1;
      end else begin
        timeout = tick && (cnt_q == terminal); // R2
      end
    end
  end

  // ---------------------------------------------------------------
  // Control register and unlock state
  // ---------------------------------------------------------------
  // The unlock opens for exactly the next SFR write of any address, so any
  // unrelated write in between cancels it and the sequence must be redone.
  always_comb begin
    ctrl_d = ctrl_q;
    unlock_d = unlock_q;
    if (accept) begin
      ctrl_d = new_val; // R6
      ctrl_d[`WDT_BIT_UNLOCK] = 1'b0;
      unlock_d = 1'b0;
    end else if (hit && new_val[`WDT_BIT_UNLOCK]) begin
      unlock_d = 1'b1; // R6
    end else if (sfr_wr || sfr_bit_wr) begin
      unlock_d = 1'b0;
    end
    // A timeout in the cycle of a clearing write still leaves the flag set.
    if (timeout) begin
      ctrl_d[`WDT_BIT_FLAG] = 1'b1; // R2
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= `WDT_CTRL_RESET; // R7
      unlock_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      unlock_q <= unlock_d;
    end
  end

  // ---------------------------------------------------------------
  // Timeout counter
  // ---------------------------------------------------------------
  // The counter is held at zero while disabled so re-enabling starts clean.
  always_comb begin
    cnt_d = cnt_q;
    if (!enabled || refresh || timeout) begin
      cnt_d = `WDT_CNT_ZERO; // R11
    end else if (tick) begin
      cnt_d = cnt_q + 16'h0001; // R3
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= `WDT_CNT_ZERO;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // ---------------------------------------------------------------
  // Response outputs and read data
  // ---------------------------------------------------------------
  // The interrupt request follows the sticky flag while the interrupt option is set and ignores any global
  // interrupt disable, since it is taken straight to the core as a level.
  always_comb begin
    rst_d = timeout && !ctrl_q[`WDT_BIT_IRQ_SEL]; // R2
    irq_d = ctrl_d[`WDT_BIT_FLAG] && ctrl_d[`WDT_BIT_IRQ_SEL]; // R9
    rdata_d = 8'h00;
    if (sfr_rd && (sfr_addr == `WDT_CTRL_ADDR)) begin
      rdata_d = ctrl_q;
      rdata_d[`WDT_BIT_UNLOCK] = unlock_q;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_q <= 1'b0;
      irq_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      rst_q <= rst_d;
      irq_q <= irq_d;
      rdata_q <= rdata_d;
    end
  end

  assign wd_reset_req = rst_q;
  assign wd_irq = irq_q;
  assign sfr_rdata = rdata_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  // Marks the first cycle after reset release for the reset-value check.
  logic seen_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= 1'b1;
    end
  end

  sequence s_expire;
    enabled && tick && (pre <= `WDT_PRE_MAX_TIMED) && (cnt_q == terminal);
  endsequence

  sequence s_locked_write;
    hit && !unlock_q && !new_val[`WDT_BIT_UNLOCK];
  endsequence

  property p_disabled_quiet;
    @(posedge clk) disable iff (!arst_n) !enabled |=> !wd_reset_req;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("reset while disabled"); // R1

  property p_expire_flags;
    @(posedge clk) disable iff (!arst_n)
      s_expire ##0 !ctrl_q[`WDT_BIT_IRQ_SEL] |=> wd_reset_req && ctrl_q[`WDT_BIT_FLAG] ##1 !wd_reset_req;
  endproperty
  a_expire_flags: assert property (p_expire_flags) else $error("missed expiry reset"); // R2

  property p_count_on_tick;
    @(posedge clk) disable iff (!arst_n)
      enabled && !tick && !refresh && !timeout |=> $stable(cnt_q);
  endproperty
  a_count_on_tick: assert property (p_count_on_tick) else $error("count moved without tick"); // R3

  property p_pre_field;
    @(posedge clk) disable iff (!arst_n)
      accept && byte_hit |=> pre == $past(sfr_wdata[7:4]);
  endproperty
  a_pre_field: assert property (p_pre_field) else $error("prescale not taken"); // R4

  property p_pre3_length;
    @(posedge clk) disable iff (!arst_n)
      enabled && pre == 4'h3 && tick && cnt_q == 16'h0FFF |=> ctrl_q[`WDT_BIT_FLAG];
  endproperty
  a_pre3_length: assert property (p_pre3_length) else $error("wrong timeout length"); // R5

  property p_locked;
    @(posedge clk) disable iff (!arst_n)
      s_locked_write ##0 !timeout |=> ctrl_q == $past(ctrl_q) && !unlock_q;
  endproperty
  a_locked: assert property (p_locked) else $error("locked write took effect"); // R6

  property p_reset_value;
    @(posedge clk) disable iff (!arst_n) !seen_q |-> ctrl_q == `WDT_CTRL_RESET;
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("bad control reset value"); // R7

  property p_other_addr;
    @(posedge clk) disable iff (!arst_n)
      sfr_wr && sfr_addr != `WDT_CTRL_ADDR && !sfr_bit_wr |=> !unlock_q;
  endproperty
  a_other_addr: assert property (p_other_addr) else $error("foreign write kept unlock"); // R8

  property p_irq_path;
    @(posedge clk) disable iff (!arst_n)
      s_expire ##0 ctrl_q[`WDT_BIT_IRQ_SEL] |=> !wd_reset_req && wd_irq;
  endproperty
  a_irq_path: assert property (p_irq_path) else $error("interrupt option failed"); // R9

  property p_refresh_clear;
    @(posedge clk) disable iff (!arst_n) refresh |=> cnt_q == `WDT_CNT_ZERO;
  endproperty
  a_refresh_clear: assert property (p_refresh_clear) else $error("refresh kept count"); // R11
endmodule

/* File: hdl/wdt_xtal_edge.sv */
// Rising-edge detector for the crystal clock level.
// Assumes the crystal level is already synchronous to clk.
`timescale 1ns/1ns
module wdt_xtal_edge
  import wdt_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic xtal_level,
  output logic tick
);
  logic prev_q;
  logic prev_d;

  // ---------------------------------------------------------------
  // Edge detect
  // ---------------------------------------------------------------
  // The previous level is remembered so one crystal period gives one tick.
  always_comb begin
    prev_d = xtal_level;
    tick = xtal_level & ~prev_q;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
    end
  end
endmodule

/* File: shared/wdt_consts.svh */
// Constants for the crystal watchdog: register address, field positions,
// reset value and counter limits. Included by every design file that needs them.
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH

`define WDT_CTRL_ADDR 8'hC0
`define WDT_CTRL_BIT_BASE 5'h18
`define WDT_CTRL_RESET 8'h10
`define WDT_BIT_REFRESH 3'h0
`define WDT_BIT_UNLOCK 3'h1
`define WDT_BIT_FLAG 3'h2
`define WDT_BIT_IRQ_SEL 3'h3
`define WDT_PRE_HI 7
`define WDT_PRE_LO 4
`define WDT_PRE_MAX_TIMED 4'h7
`define WDT_PRE_IMMEDIATE 4'h8
`define WDT_CNT_ZERO 16'h0000
`define WDT_CNT_FULL 16'hFFFF

`endif

/* File: shared/wdt_pkg.sv */
// Types shared by the crystal watchdog design files.
// Assumes the constants header is included by the files that use it.
package wdt_pkg;
  typedef logic [3:0] wdt_pre_t;
  typedef logic [15:0] wdt_cnt_t;
  typedef logic [7:0] wdt_byte_t;
endpackage

/* File: sim/wdt_core_tb.sv */
// Self-checking bench for the crystal watchdog core: register access, unlock, timeouts.
// Assumes the design files, the shared package and the constants header are compiled first.
`timescale 1ns/1ns
module wdt_core_tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic xtal_level = 1'b0;
  logic sfr_wr = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_rdata;
  logic sfr_bit_wr = 1'b0;
  logic [7:0] sfr_bit_addr = 8'h00;
  logic sfr_bit_val = 1'b0;
  logic wd_reset_req;
  logic wd_irq;
  logic rd_seen = 1'b0;
  logic [15:0] rst_cnt = 16'h0000;
  logic [15:0] base;
  logic [7:0] cfg;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'h00006F11;
  int fails = 0;
  int n_tests = 0;
  int n;

  wdt_core u_dut (
    .clk(clk), .arst_n(arst_n), .xtal_level(xtal_level),
    .sfr_wr(sfr_wr), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_bit_wr(sfr_bit_wr),
    .sfr_bit_addr(sfr_bit_addr), .sfr_bit_val(sfr_bit_val),
    .wd_reset_req(wd_reset_req), .wd_irq(wd_irq)
  );

  // Free-running 125 MHz clock.
  always #4 clk = ~clk;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Xorshift source, seeded with 28433, drives data and crystal spacing.
  function automatic logic [31:0] nxt();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d.", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Every strobe is a single-cycle pulse, so consecutive calls leave an idle cycle.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    @(posedge clk);
    #1 sfr_wr = 1'b0;
  endtask

  task automatic bw(input logic [7:0] a, input logic v);
    @(posedge clk);
    #1 sfr_bit_wr = 1'b1;
    sfr_bit_addr = a;
    sfr_bit_val = v;
    @(posedge clk);
    #1 sfr_bit_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    #1 sfr_rd = 1'b1;
    sfr_addr = a;
    exp_q.push_back(e);
    @(posedge clk);
    #1 sfr_rd = 1'b0;
  endtask

  task automatic lock_wr(input logic [7:0] v);
    bw(8'hC1, 1'b1);
    wr(8'hC0, v);
  endtask

  // Crystal ticks with a random idle gap so the edge detector sees uneven spacing.
  task automatic ticks(input int k);
    for (int i = 0; i < k; i++) begin
      @(posedge clk);
      #1 xtal_level = 1'b1;
      @(posedge clk);
      #1 xtal_level = 1'b0;
      repeat (nxt() % 3) @(posedge clk);
    end
  endtask

  // Monitor: counts cycles with the reset request high and matches each read answer to the oldest note.
  always @(posedge clk) begin
    if (wd_reset_req === 1'b1) rst_cnt <= rst_cnt + 16'h0001;
    if (rd_seen && exp_q.size() > 0) check({8'h00, sfr_rdata}, {8'h00, exp_q.pop_front()});
    rd_seen <= sfr_rd;
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    #1 arst_n = 1'b1;
    rd(8'hC0, 8'h10);
    rd(8'h80, 8'h00);
    wr(8'hC0, nxt() & 8'hFD);
    rd(8'hC0, 8'h10);
    bw(8'hC1, 1'b1);
    wr(8'h80, nxt());
    wr(8'hC0, 8'h01);
    rd(8'hC0, 8'h10);
    // Refresh halfway, then the full interval must elapse from the refresh.
    for (int p = 0; p < 3; p++) begin
      n = 512 << p;
      cfg = {4'(p), 4'h1};
      lock_wr(cfg);
      ticks(n / 2);
      lock_wr(cfg);
      base = rst_cnt;
      ticks(n - 1);
      check(rst_cnt, base);
      ticks(1);
      repeat (6) @(posedge clk);
      check(rst_cnt, base + 16'h0001);
      check({15'h0000, wd_irq}, 16'h0000);
      rd(8'hC0, cfg | 8'h04);
    end
    lock_wr(8'h00);
    base = rst_cnt;
    ticks(600);
    check(rst_cnt, base);
    check({15'h0000, wd_irq}, 16'h0000);
    lock_wr(8'h09);
    ticks(512);
    repeat (6) @(posedge clk);
    check(rst_cnt, base);
    check({15'h0000, wd_irq}, 16'h0001);
    rd(8'hC0, 8'h0D);
    lock_wr(8'h0D);
    bw(8'hC1, 1'b1);
    bw(8'hC2, 1'b0);
    repeat (4) @(posedge clk);
    check({15'h0000, wd_irq}, 16'h0000);
    bw(8'hC1, 1'b1);
    bw(8'hC0, 1'b0);
    rd(8'hC0, 8'h08);
    lock_wr(8'h81);
    repeat (4) @(posedge clk);
    check({15'h0000, rst_cnt != base}, 16'h0001);
    lock_wr(8'h80);
    repeat (4) @(posedge clk);
    test_done();
  end

  // Watchdog: the scenarios need about 20k cycles; 80k means a hang.
  initial begin
    #(8 * 80000);
    fails++;
    test_done();
  end
endmodule
